//--- hdl/aar_signal_router.sv
// Operation
// - Single-ended bit 0 gives differential receive, 1 joins both pins.
// - Mixer-direct-ADC bit connects I/Q mixer outputs straight to ADC.
// - Output selector 0100 drives aux output with transmit envelope.
// - Output selector 0110 gives Manchester data, 0111 Manchester with subcarrier.
// - Input selector 10 takes aux input as Type A, 11 as generic.
// - Input selector 01 uses internal receive path.
// - Driver selector 00 holds the antenna driver low.
// - Driver selector 10 modulates from aux input; repeat receive keeps reception.
`timescale 1ns/1ps
`default_nettype none
`include "aar_params.svh"

module aar_signal_router (
   input wire logic ref_clk_i, // 250 MHz system clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [7:0] reg_addr_i, // Register byte address
   input wire aar_pkg::aar_data_t reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output var aar_pkg::aar_data_t reg_rdata_o, // Read data, cycle after strobe
   input wire logic transmit_envelope_i, // Coder envelope
   input wire logic rx_manchester_i, // Decoded Manchester data
   input wire logic rx_manch_subc_i, // Manchester with subcarrier
   input wire logic rx_internal_i, // Internal receive path
   input wire logic aux_signal_in_i, // Aux input pin (async)
   output logic aux_signal_out_o, // Aux output pin
   output logic antenna_drive_o, // Driver modulation source
   output logic decoder_rx_o, // Receive signal to decoder
   output logic decoder_generic_o, // Decoder treats input as generic code
   output logic rx_single_ended_o, // Receiver quasi-differential
   output logic mixer_direct_adc_o, // Mixers wired to ADC
   output logic repeat_receive_en_o // Reception stays active
);
   import aar_pkg::*;

   logic [7:0] rcv_q, rcv_d;
   logic [3:0] outsel_q, outsel_d;
   logic [1:0] drvsel_q, drvsel_d;
   logic rxc_q, rxc_d;
   aar_data_t rdata_q, rdata_d;
   logic sin_m_q, sin_q;
   logic aux_out_q, aux_out_d;
   logic drive_q, drive_d;
   logic dec_q, dec_d;
   logic [1:0] insel;
   logic sin_m_d, sin_d;
   logic hit_rcv, hit_outsel, hit_drv, hit_rxc, hit_status;

   assign insel = rcv_q[`AAR_RCV_INSEL_LSB +: 2];

   // Address decode shared by writes and reads
   assign hit_rcv = (reg_addr_i == `AAR_OFF_RECEIVER_CONFIG);
   assign hit_outsel = (reg_addr_i == `AAR_OFF_AUX_OUTPUT_CONFIG);
   assign hit_drv = (reg_addr_i == `AAR_OFF_DRIVER_CONFIG);
   assign hit_rxc = (reg_addr_i == `AAR_OFF_RECEIVE_CONTROL);
   assign hit_status = (reg_addr_i == `AAR_OFF_STATUS);

   // Control registers
   always_comb begin
      rcv_d = rcv_q;
      outsel_d = outsel_q;
      drvsel_d = drvsel_q;
      rxc_d = rxc_q;
      if (reg_wr_i) begin
         if (hit_rcv) begin
            rcv_d = reg_wdata_i;
         end
         if (hit_outsel) begin
            outsel_d = reg_wdata_i[3:0];
         end
         if (hit_drv) begin
            drvsel_d = reg_wdata_i[1:0];
         end
         if (hit_rxc) begin
            rxc_d = reg_wdata_i[`AAR_RXC_REPEAT_BIT];
         end
      end
   end

   // Read data, zero outside the answer cycle
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd_i) begin
         if (hit_rcv) begin
            rdata_d = rcv_q;
         end else if (hit_outsel) begin
            rdata_d = {4'h0, outsel_q};
         end else if (hit_drv) begin
            rdata_d = {6'h00, drvsel_q};
         end else if (hit_rxc) begin
            rdata_d = {7'h00, rxc_q};
         end else if (hit_status) begin
            rdata_d = {5'h00, dec_q, drive_q, aux_out_q};
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   // Aux output source
   always_comb begin
      aux_out_d = 1'b0;
      case (aar_outsel_e'(outsel_q))
         AAR_OUT_TX_ENVELOPE: aux_out_d = transmit_envelope_i;
         AAR_OUT_RX_MANCHESTER: aux_out_d = rx_manchester_i;
         AAR_OUT_RX_MANCH_SUBC: aux_out_d = rx_manch_subc_i;
         default: aux_out_d = 1'b0;
      endcase
   end

   // Receive source to decoder
   always_comb begin
      dec_d = 1'b0;
      case (aar_insel_e'(insel))
         AAR_IN_INTERNAL: dec_d = rx_internal_i;
         AAR_IN_AUX_TYPEA: dec_d = sin_q;
         AAR_IN_AUX_GENERIC: dec_d = sin_q;
         default: dec_d = 1'b0;
      endcase
   end

   // Antenna driver source
   always_comb begin
      drive_d = 1'b0;
      case (aar_drvsel_e'(drvsel_q))
         AAR_DRV_IDLE: drive_d = 1'b0;
         AAR_DRV_INTERNAL: drive_d = transmit_envelope_i;
         AAR_DRV_AUX_IN: drive_d = sin_q;
         default: drive_d = 1'b0;
      endcase
   end

   // Control register group
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rcv_q <= `AAR_RCV_RESET;
         outsel_q <= `AAR_OUTSEL_RESET;
         drvsel_q <= `AAR_DRV_RESET;
         rxc_q <= `AAR_RXC_RESET;
      end else begin
         rcv_q <= rcv_d;
         outsel_q <= outsel_d;
         drvsel_q <= drvsel_d;
         rxc_q <= rxc_d;
      end
   end

   // Read data group
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Pin is asynchronous: two stages, only the second is read
   always_comb begin
      sin_m_d = aux_signal_in_i;
      sin_d = sin_m_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sin_m_q <= 1'b0;
         sin_q <= 1'b0;
      end else begin
         sin_m_q <= sin_m_d;
         sin_q <= sin_d;
      end
   end

   // Aux output register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aux_out_q <= 1'b0;
      end else begin
         aux_out_q <= aux_out_d;
      end
   end

   // Driver register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= drive_d;
      end
   end

   // Decoder input register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dec_q <= 1'b0;
      end else begin
         dec_q <= dec_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign aux_signal_out_o = aux_out_q;
   assign antenna_drive_o = drive_q;
   assign decoder_rx_o = dec_q;
   assign decoder_generic_o = (insel == AAR_IN_AUX_GENERIC);
   assign rx_single_ended_o = rcv_q[`AAR_RCV_SINGLE_BIT];
   assign mixer_direct_adc_o = rcv_q[`AAR_RCV_ADC_BIT];
   assign repeat_receive_en_o = rxc_q;
endmodule

`default_nettype wire

//--- hdl/aar_params.svh
`ifndef AAR_PARAMS_SVH
`define AAR_PARAMS_SVH

// Register offsets
`define AAR_ADDR_W 8
`define AAR_OFF_RECEIVER_CONFIG 8'h38
`define AAR_OFF_AUX_OUTPUT_CONFIG 8'h3C
`define AAR_OFF_DRIVER_CONFIG 8'h40
`define AAR_OFF_RECEIVE_CONTROL 8'h44
`define AAR_OFF_STATUS 8'h48

// receiver_config fields
`define AAR_RCV_SINGLE_BIT 0
`define AAR_RCV_ADC_BIT 1
`define AAR_RCV_INSEL_LSB 2
`define AAR_RCV_RESET 8'h04

// aux_output_config fields
`define AAR_OUTSEL_RESET 4'h0

// driver_config fields
`define AAR_DRV_RESET 2'h0

// receive_control fields
`define AAR_RXC_REPEAT_BIT 0
`define AAR_RXC_RESET 1'h0

`endif

//--- hdl/aar_pkg.sv
package aar_pkg;
   typedef enum logic [3:0] {
      AAR_OUT_LOW = 4'h0,
      AAR_OUT_TX_ENVELOPE = 4'h4,
      AAR_OUT_RX_MANCHESTER = 4'h6,
      AAR_OUT_RX_MANCH_SUBC = 4'h7
   } aar_outsel_e;
   typedef enum logic [1:0] {
      AAR_IN_NONE = 2'h0,
      AAR_IN_INTERNAL = 2'h1,
      AAR_IN_AUX_TYPEA = 2'h2,
      AAR_IN_AUX_GENERIC = 2'h3
   } aar_insel_e;
   typedef enum logic [1:0] {
      AAR_DRV_IDLE = 2'h0,
      AAR_DRV_INTERNAL = 2'h1,
      AAR_DRV_AUX_IN = 2'h2,
      AAR_DRV_RSVD = 2'h3
   } aar_drvsel_e;
   typedef logic [7:0] aar_data_t;
endpackage

//--- bench/aar_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aar_chk (
   input wire logic ref_clk_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic [7:0] reg_addr_i, // Address
   input wire aar_pkg::aar_data_t reg_wdata_i, // Data
   input wire logic reg_wr_i, // Write
   input wire logic transmit_envelope_i, // Envelope
   input wire logic rx_manchester_i, // Manchester
   input wire logic rx_manch_subc_i, // Subcarrier
   input wire logic rx_internal_i, // Internal
   input wire logic aux_signal_in_i, // Aux in
   input wire logic aux_signal_out_o, // Aux out
   input wire logic antenna_drive_o, // Drive
   input wire logic decoder_rx_o, // Decoder
   input wire logic decoder_generic_o, // Generic
   input wire logic rx_single_ended_o, // Single
   input wire logic mixer_direct_adc_o // Mixer
);
   import aar_pkg::*;
   logic [3:0] r, o;
   logic [1:0] d;
   // Shadow of the selectors
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
      if (!rst_n_i) {r, o, d} <= 10'h100;
      else if (reg_wr_i && reg_addr_i == 8'h38) r <= reg_wdata_i[3:0];
      else if (reg_wr_i && reg_addr_i == 8'h3C) o <= reg_wdata_i[3:0];
      else if (reg_wr_i && reg_addr_i == 8'h40) d <= reg_wdata_i[1:0];
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_se; rx_single_ended_o == r[0]; endproperty
   a_se: assert property (p_se) else $error("single");
   property p_adc; mixer_direct_adc_o == r[1]; endproperty
   a_adc: assert property (p_adc) else $error("mixer");
   property p_gen; decoder_generic_o == (r[3:2] == 2'h3); endproperty
   a_gen: assert property (p_gen) else $error("generic");
   property p_int; r[3:2] == 2'h1 |=> decoder_rx_o == $past(rx_internal_i); endproperty
   a_int: assert property (p_int) else $error("internal");
   property p_env; o == 4'h4 |=> aux_signal_out_o == $past(transmit_envelope_i); endproperty
   a_env: assert property (p_env) else $error("envelope");
   property p_low; !(o inside {4'h4, 4'h6, 4'h7}) |=> !aux_signal_out_o; endproperty
   a_low: assert property (p_low) else $error("aux low");
   property p_idle; d == 2'h0 |=> !antenna_drive_o; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_drv; d == 2'h1 |=> antenna_drive_o == $past(transmit_envelope_i); endproperty
   a_drv: assert property (p_drv) else $error("drive");
   property p_man; o == 4'h6 |=> aux_signal_out_o == $past(rx_manchester_i); endproperty
   a_man: assert property (p_man) else $error("manchester");
   property p_subc; o == 4'h7 |=> aux_signal_out_o == $past(rx_manch_subc_i); endproperty
   a_subc: assert property (p_subc) else $error("subcarrier");
   property p_pin_drv; d == 2'h2 |=> antenna_drive_o == $past(aux_signal_in_i, 3); endproperty
   a_pin_drv: assert property (p_pin_drv) else $error("aux drive");
   property p_pin_dec; r[3] |=> decoder_rx_o == $past(aux_signal_in_i, 3); endproperty
   a_pin_dec: assert property (p_pin_dec) else $error("aux receive");
endmodule
`default_nettype wire

//--- bench/aar_peer.sv
`timescale 1ns/1ps
`default_nettype none
module aar_peer (
   input wire logic clk_i, // Clock
   input wire logic send_i, // Send mark
   output logic pin_o // Aux pin
);
   logic t_q = 1'h0;
   always @(posedge clk_i) t_q <= ~t_q;
   assign pin_o = send_i | t_q;
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0, send = 1'h0;
   logic transmit_envelope_i = 1'h0, rx_manchester_i = 1'h0, rx_manch_subc_i = 1'h0, rx_internal_i = 1'h0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic aux_signal_in_i, aux_signal_out_o, antenna_drive_o, decoder_rx_o, decoder_generic_o;
   logic rx_single_ended_o, mixer_direct_adc_o, repeat_receive_en_o;
   logic [1:0] seen;
   int errors = 0, cmp_count = 0;
   // Address, data, sources, expected outputs
   logic [31:0] t [13] = '{32'h380B0134, 32'h380E0164, 32'h38040204, 32'h3C041001, 32'h3C060801,
      32'h3C070401, 32'h3C051C00, 32'h40011002, 32'h40031100, 32'h38000200, 32'h40020102,
      32'h40001100, 32'h44010008};
   wire logic [7:0] obs = {1'h0, decoder_generic_o, mixer_direct_adc_o, rx_single_ended_o,
      repeat_receive_en_o, decoder_rx_o, antenna_drive_o, aux_signal_out_o};
   aar_signal_router dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .transmit_envelope_i(transmit_envelope_i), .rx_manchester_i(rx_manchester_i),
      .rx_manch_subc_i(rx_manch_subc_i), .rx_internal_i(rx_internal_i), .aux_signal_in_i(aux_signal_in_i),
      .aux_signal_out_o(aux_signal_out_o), .antenna_drive_o(antenna_drive_o), .decoder_rx_o(decoder_rx_o),
      .decoder_generic_o(decoder_generic_o), .rx_single_ended_o(rx_single_ended_o),
      .mixer_direct_adc_o(mixer_direct_adc_o), .repeat_receive_en_o(repeat_receive_en_o)
   );
   aar_peer peer (.clk_i(ref_clk_i), .send_i(send), .pin_o(aux_signal_in_i));
   always #2 ref_clk_i = ~ref_clk_i;
   task automatic chk(input string n, input logic [7:0] e, s);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge ref_clk_i);
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
      @(posedge ref_clk_i);
      {reg_wr_i, reg_rd_i} <= 2'h0;
      if (!w) #1 chk("read", d, reg_rdata_o);
   endtask
   task automatic end_sim();
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'h1;
      acc(1'h0, 8'h38, 8'h04);
      foreach (t[i]) begin
         acc(1'h1, t[i][31:24], t[i][23:16]);
         {transmit_envelope_i, rx_manchester_i, rx_manch_subc_i, rx_internal_i, send} <= t[i][12:8];
         repeat (4) @(posedge ref_clk_i);
         #1 chk("outputs", t[i][7:0], obs);
      end
      acc(1'h1, 8'h40, 8'h02);
      acc(1'h1, 8'h38, 8'h08);
      repeat (4) @(posedge ref_clk_i);
      #1 seen = {decoder_rx_o, antenna_drive_o};
      @(posedge ref_clk_i);
      #1 chk("aux follow", {6'h00, ~seen}, {6'h00, decoder_rx_o, antenna_drive_o});
      acc(1'h1, 8'h50, 8'hFF);
      acc(1'h0, 8'h50, 8'h00);
      acc(1'h0, 8'h3C, 8'h05);
      end_sim();
   end
   initial begin
      #4000 errors++;
      end_sim();
   end
endmodule
bind aar_signal_router aar_chk u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .transmit_envelope_i(transmit_envelope_i), .rx_manchester_i(rx_manchester_i),
   .rx_manch_subc_i(rx_manch_subc_i), .rx_internal_i(rx_internal_i), .aux_signal_in_i(aux_signal_in_i),
   .aux_signal_out_o(aux_signal_out_o), .antenna_drive_o(antenna_drive_o), .decoder_rx_o(decoder_rx_o),
   .decoder_generic_o(decoder_generic_o), .rx_single_ended_o(rx_single_ended_o),
   .mixer_direct_adc_o(mixer_direct_adc_o)
);
`default_nettype wire
